//--- design/sar_adc_sequencer.sv
// Sequencer for a 12-bit successive-approximation converter: registers,
// start selection, tracking, burst power-up, accumulation and result format.
// Assumes a register port on clk_sys, a same-clock converter core and timers.
//
// Contract
// - Selector codes map to ports, temp, supply, ground.
// - Selector upper three bits read zero.
// - Conversion clock is subsystem clock over divisor+1.
// - Subsystem clock is system clock or burst source.
// - Repeat field selects 1, 4, 8, 16 conversions.
// - Burst runs whole series from one start.
// - Accumulator returns to zero after last conversion.
// - Configuration bit zero reads zero, written zero.
// - Right-justified high byte holds upper sum bits.
// - Low byte and left-justified layout as specified.
// - Enable clear means shutdown, set means active.
// - Done flag sets as busy falls, sticky.
// - Busy reads activity; writing one starts if software.
// - Window flag set by match, cleared by software.
// - Start source selects software, timers or pin.
// - Burst power-up waits (field+1) times 400 ns.
// - Power state follows enable and burst settings.
// - Tracking mode: post, pre, dual, reserved.
// - Tracking lasts 2-16 conversion clocks plus two.
// - Conversion lasts thirteen conversion clocks plus two.
// - Pre-tracking converts immediately after a start outside burst mode.
`timescale 1ns/100ps
`include "sar_adc_defs.svh"
module sar_adc_sequencer (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr_en,
    input  wire logic        sfr_rd_en,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata_q,
    input  wire logic        burst_osc_tick,
    input  wire logic        timer2_overflow,
    input  wire logic        timer3_overflow,
    input  wire logic        external_start_pin,
    input  wire logic        window_match_event,
    input  wire logic [11:0] core_result_data,
    output logic      [23:0] mux_port_sel_q,
    output logic             mux_temp_sel_q,
    output logic             mux_supply_sel_q,
    output logic             mux_ground_sel_q,
    output logic             core_power_q,
    output logic             core_track_q,
    output logic             core_convert_q,
    output logic             sar_conversion_clock,
    output logic             conversion_done_event_q
);

    // Register state.
    logic [7:0]  timing_q;
    logic [4:0]  channel_q;
    logic [7:0]  config_q;
    logic [7:0]  result_lo_q;
    logic [7:0]  result_hi_q;
    logic        enable_q;
    logic        burst_q;
    logic        done_q;
    logic        window_q;
    logic        ljust_q;
    logic [1:0]  source_q;

    // Sequencer state.
    sar_adc_pkg::seq_state_e st_q;
    sar_adc_pkg::seq_state_e st_d;
    logic [1:0]  lead_q;
    logic [4:0]  sar_cnt_q;
    logic [7:0]  pwr_cnt_q;
    logic [3:0]  rep_q;
    logic [15:0] acc_q;
    logic        pin_s1_q;
    logic        pin_s2_q;
    logic        pin_s3_q;

    // Field views.
    wire [3:0] pwr_field   = timing_q[7:4];
    wire [1:0] tmode       = timing_q[3:2];
    wire [1:0] post_track  = timing_q[1:0];
    wire [4:0] divisor     = config_q[7:3];
    wire [1:0] repeat_code = config_q[2:1];

    // Address decode.
    wire wr_timing  = sfr_wr_en && (sfr_addr == `ADDR_TRACK_TIMING);
    wire wr_channel = sfr_wr_en && (sfr_addr == `ADDR_CHANNEL_SEL);
    wire wr_config  = sfr_wr_en && (sfr_addr == `ADDR_CONFIG);
    wire wr_res_lo  = sfr_wr_en && (sfr_addr == `ADDR_RESULT_LO);
    wire wr_res_hi  = sfr_wr_en && (sfr_addr == `ADDR_RESULT_HI);
    wire wr_control = sfr_wr_en && (sfr_addr == `ADDR_CONTROL);

    // Start events; the pin edge is taken only after its two-flop synchroniser.
    wire pin_rise  = pin_s2_q && !pin_s3_q;
    wire sw_start  = wr_control && sfr_wdata[`CTL_BUSY_BIT] && (sfr_wdata[1:0] == 2'h0);
    wire start_ev  = sw_start
                   || (source_q == sar_adc_pkg::SRC_TIMER3 && timer3_overflow)
                   || (source_q == sar_adc_pkg::SRC_PIN && pin_rise)
                   || (source_q == sar_adc_pkg::SRC_TIMER2 && timer2_overflow);
    wire is_idle   = (st_q == sar_adc_pkg::ST_IDLE);
    wire accept    = is_idle && start_ev && (enable_q || burst_q);
    wire busy      = !is_idle;

    // Subsystem clock: every system clock, or the burst oscillator tick.
    wire converter_subsystem_clock_tick = burst_q ? burst_osc_tick : 1'b1;

    // Phase timing: two subsystem clocks lead, then counted conversion clocks.
    wire       in_phase   = (st_q == sar_adc_pkg::ST_TRACK) || (st_q == sar_adc_pkg::ST_CONVERT);
    wire       lead_done  = (lead_q == `CONVERTER_SUBSYSTEM_CLOCK_LEAD_CYC);
    wire [4:0] track_need = 5'(5'h02 << post_track);
    wire [4:0] phase_need = (st_q == sar_adc_pkg::ST_TRACK) ? track_need
                                                            : `CONVERT_SAR_CYC;
    wire       phase_end  = in_phase && lead_done && sar_conversion_clock
                            && (sar_cnt_q == phase_need - 5'h01);
    wire       conv_end   = (st_q == sar_adc_pkg::ST_CONVERT) && phase_end;

    // Power-up wait in system clocks, rounded up from 400 ns units.
    wire [7:0] pwr_target = 8'((9'(pwr_field) + 9'h001) * 9'(`POWERUP_UNIT_CYC)) - 8'h01;
    wire       pwr_done   = (pwr_cnt_q == pwr_target);

    // Repeat series bookkeeping.
    wire [3:0]  last_rep = (repeat_code == 2'h0) ? 4'h0 :
                           (repeat_code == 2'h1) ? 4'h3 :
                           (repeat_code == 2'h2) ? 4'h7 : 4'hf;
    wire        last_conv = (rep_q == last_rep);
    wire [15:0] sum       = acc_q + {4'h0, core_result_data};
    wire        series_end = conv_end && last_conv;

    // Result layout; left justification is honoured only for single samples,
    // since a repeated sum would not fit the left-justified form.
    wire        use_left  = ljust_q && (repeat_code == 2'h0);
    wire [7:0]  new_hi    = use_left ? sum[11:4] : sum[15:8];
    wire [7:0]  new_lo    = use_left ? {sum[3:0], 4'h0} : sum[7:0];

    // Power and track outputs computed from the next state so they align.
    wire idle_next   = (st_d == sar_adc_pkg::ST_IDLE);
    wire power_d     = burst_q ? (enable_q || !idle_next) : enable_q;
    wire track_d     = (st_d == sar_adc_pkg::ST_TRACK)
                       || (idle_next && power_d && tmode != sar_adc_pkg::TM_POST
                           && tmode != sar_adc_pkg::TM_RESERVED);

    // Read data; unmapped addresses read zero.
    wire [7:0] control_rd = {enable_q, burst_q, done_q, busy, window_q, ljust_q, source_q};
    wire [7:0] rdata_d =
        (sfr_addr == `ADDR_TRACK_TIMING) ? timing_q :
        (sfr_addr == `ADDR_CHANNEL_SEL)  ? {3'h0, channel_q} :
        (sfr_addr == `ADDR_CONFIG)       ? {config_q[7:1], 1'b0} :
        (sfr_addr == `ADDR_RESULT_LO)    ? result_lo_q :
        (sfr_addr == `ADDR_RESULT_HI)    ? result_hi_q :
        (sfr_addr == `ADDR_CONTROL)      ? control_rd : 8'h00;

    // Conversion clock divider, held in restart until the lead cycles pass.
    sar_clock_divider #(.DIV_W(5)) u_div (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .clk_en     (clk_en),
        .converter_subsystem_clock_tick  (converter_subsystem_clock_tick),
        .run        (in_phase && lead_done && !phase_end),
        .divisor    (divisor),
        .sar_tick_q (sar_conversion_clock)
    );

    // Next-state decision. Clearing enable outside burst aborts the sequence
    // and leaves the partial sum and repeat count, which the next series continues from.
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            sar_adc_pkg::ST_IDLE: begin
                if (accept) begin
                    if (burst_q && !enable_q) st_d = sar_adc_pkg::ST_POWERUP;
                    else if (!burst_q && tmode == sar_adc_pkg::TM_PRE)
                        st_d = sar_adc_pkg::ST_CONVERT;
                    else st_d = sar_adc_pkg::ST_TRACK;
                end
            end
            sar_adc_pkg::ST_POWERUP: begin
                if (pwr_done) st_d = sar_adc_pkg::ST_TRACK;
            end
            sar_adc_pkg::ST_TRACK: begin
                if (phase_end) st_d = sar_adc_pkg::ST_CONVERT;
            end
            sar_adc_pkg::ST_CONVERT: begin
                if (phase_end) begin
                    if (!last_conv && burst_q) st_d = sar_adc_pkg::ST_TRACK;
                    else st_d = sar_adc_pkg::ST_IDLE;
                end
            end
        endcase
        if (!burst_q && !enable_q) st_d = sar_adc_pkg::ST_IDLE;
    end

    // State, phase counters and the pin synchroniser.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_q      <= sar_adc_pkg::ST_IDLE;
            lead_q    <= 2'h0;
            sar_cnt_q <= 5'h00;
            pwr_cnt_q <= 8'h00;
            pin_s1_q  <= 1'b0;
            pin_s2_q  <= 1'b0;
            pin_s3_q  <= 1'b0;
        end else if (clk_en) begin
            st_q      <= st_d;
            pin_s1_q  <= external_start_pin;
            pin_s2_q  <= pin_s1_q;
            pin_s3_q  <= pin_s2_q;
            lead_q    <= (st_d != st_q) ? 2'h0 :
                         (in_phase && converter_subsystem_clock_tick && !lead_done) ? lead_q + 2'h1 : lead_q;
            sar_cnt_q <= (st_d != st_q) ? 5'h00 :
                         sar_conversion_clock ? sar_cnt_q + 5'h01 : sar_cnt_q;
            pwr_cnt_q <= (st_q == sar_adc_pkg::ST_POWERUP) ? pwr_cnt_q + 8'h01 : 8'h00;
        end
    end

    // Accumulator and repeat counter; cleared at the end of every series.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            acc_q <= 16'h0000;
            rep_q <= 4'h0;
        end else if (clk_en && conv_end) begin
            acc_q <= last_conv ? 16'h0000 : sum;
            rep_q <= last_conv ? 4'h0 : rep_q + 4'h1;
        end
    end

    // Software-written registers; the reserved configuration bit stays zero.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            timing_q  <= `RST_TRACK_TIMING;
            channel_q <= `RST_CHANNEL_SEL;
            config_q  <= `RST_CONFIG;
            enable_q  <= 1'b0;
            burst_q   <= 1'b0;
            ljust_q   <= 1'b0;
            source_q  <= 2'h0;
        end else if (clk_en) begin
            if (wr_timing) timing_q <= sfr_wdata;
            if (wr_channel) channel_q <= sfr_wdata[4:0];
            if (wr_config) config_q <= {sfr_wdata[7:1], 1'b0};
            if (wr_control) begin
                enable_q <= sfr_wdata[`CTL_ENABLE_BIT];
                burst_q  <= sfr_wdata[`CTL_BURST_BIT];
                ljust_q  <= sfr_wdata[`CTL_LJUST_BIT];
                source_q <= sfr_wdata[1:0];
            end
        end
    end

    // Sticky flags: a hardware set in the same cycle as a software clear wins.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            done_q   <= 1'b0;
            window_q <= 1'b0;
        end else if (clk_en) begin
            done_q   <= series_end || (wr_control ? sfr_wdata[`CTL_DONE_BIT] : done_q);
            window_q <= window_match_event
                        || (wr_control ? sfr_wdata[`CTL_WINDOW_BIT] : window_q);
        end
    end

    // Result bytes change only at series end; software may also write them.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            result_lo_q <= `RST_RESULT;
            result_hi_q <= `RST_RESULT;
        end else if (clk_en) begin
            if (series_end) begin
                result_lo_q <= new_lo;
                result_hi_q <= new_hi;
            end else begin
                if (wr_res_lo) result_lo_q <= sfr_wdata;
                if (wr_res_hi) result_hi_q <= sfr_wdata;
            end
        end
    end

    // Registered outputs toward the core and the register port.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sfr_rdata_q             <= 8'h00;
            core_power_q            <= 1'b0;
            core_track_q            <= 1'b0;
            core_convert_q          <= 1'b0;
            conversion_done_event_q <= 1'b0;
        end else if (clk_en) begin
            if (sfr_rd_en) sfr_rdata_q <= rdata_d;
            core_power_q            <= power_d;
            core_track_q            <= track_d;
            core_convert_q          <= (st_d == sar_adc_pkg::ST_CONVERT);
            conversion_done_event_q <= series_end;
        end
    end

    // Input multiplexer decode, one flop per selection line.
    for (genvar i = 0; i < `MUX_PORT_COUNT; i++) begin : g_port
        always_ff @(posedge clk_sys) begin
            if (!reset_n) mux_port_sel_q[i] <= 1'b0;
            else if (clk_en) mux_port_sel_q[i] <= (channel_q == 5'(i));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            mux_temp_sel_q   <= 1'b0;
            mux_supply_sel_q <= 1'b0;
            mux_ground_sel_q <= 1'b0;
        end else if (clk_en) begin
            mux_temp_sel_q   <= (channel_q == `MUX_TEMP_CODE);
            mux_supply_sel_q <= (channel_q == `MUX_SUPPLY_CODE);
            mux_ground_sel_q <= (channel_q > `MUX_SUPPLY_CODE);
        end
    end

    // Checks on the sequencer's own behaviour.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    mux_upper_zero_a: assert property (clk_en && sfr_rd_en && sfr_addr == `ADDR_CHANNEL_SEL
        |=> sfr_rdata_q[7:5] == 3'h0) else $error("Selector upper bits not zero.");
    mux_ground_map_a: assert property (reset_n && clk_en
        |=> mux_ground_sel_q == ($past(channel_q) > 5'h19))
        else $error("Ground selection does not follow code.");
    cfg_bit_zero_a: assert property (config_q[0] == 1'b0)
        else $error("Reserved configuration bit set.");
    done_on_end_a: assert property (clk_en && series_end |=> done_q && is_idle)
        else $error("Done flag not set as busy falls.");
    acc_cleared_a: assert property (clk_en && series_end |=> acc_q == 16'h0000)
        else $error("Accumulator not cleared after series.");
    window_sticky_a: assert property (window_q && !(clk_en && wr_control) |=> window_q)
        else $error("Window flag cleared by hardware.");
    powerup_hold_a: assert property (clk_en && st_q == sar_adc_pkg::ST_POWERUP && !pwr_done
        |=> st_q == sar_adc_pkg::ST_POWERUP) else $error("Power-up wait cut short.");
    power_follow_a: assert property (clk_en && !burst_q |=> core_power_q == $past(enable_q))
        else $error("Power does not follow enable.");
    pretrack_now_a: assert property (clk_en && accept && !burst_q
        && tmode == sar_adc_pkg::TM_PRE |=> core_convert_q) else $error("Pre-track did not convert.");
    sw_start_gate_a: assert property (clk_en && is_idle && wr_control && sfr_wdata[1:0] != 2'h0
        && !timer2_overflow && !timer3_overflow && !pin_rise |=> is_idle)
        else $error("Busy write started with hardware source.");

    series_cover_c: cover property (series_end && repeat_code == 2'h3);
    burst_cover_c: cover property (st_q == sar_adc_pkg::ST_POWERUP ##1 st_q == sar_adc_pkg::ST_TRACK);
    left_cover_c: cover property (series_end && use_left);

endmodule : sar_adc_sequencer

//--- design/sar_adc_defs.svh
// Register addresses, reset values, field positions and timing counts of the
// converter sequencer. Included by bare name; holds definitions only.
`ifndef SAR_ADC_DEFS_SVH
`define SAR_ADC_DEFS_SVH

// Special-function register addresses.
`define ADDR_TRACK_TIMING  8'hba
`define ADDR_CHANNEL_SEL   8'hbb
`define ADDR_CONFIG        8'hbc
`define ADDR_RESULT_LO     8'hbd
`define ADDR_RESULT_HI     8'hbe
`define ADDR_CONTROL       8'he8

// Reset values.
`define RST_TRACK_TIMING   8'hff
`define RST_CHANNEL_SEL    5'h1f
`define RST_CONFIG         8'hf8
`define RST_RESULT         8'h00

// Control register bit positions.
`define CTL_ENABLE_BIT     7
`define CTL_BURST_BIT      6
`define CTL_DONE_BIT       5
`define CTL_BUSY_BIT       4
`define CTL_WINDOW_BIT     3
`define CTL_LJUST_BIT      2

// Input selector codes.
`define MUX_PORT_COUNT     24
`define MUX_TEMP_CODE      5'h18
`define MUX_SUPPLY_CODE    5'h19

// Timing: system clock period, power-up unit and conversion lengths.
`define CLK_PERIOD_NS      50
`define POWERUP_UNIT_NS    400
`define POWERUP_UNIT_CYC   ((`POWERUP_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONVERTER_SUBSYSTEM_CLOCK_LEAD_CYC      2'h2
`define CONVERT_SAR_CYC    5'h0d

`endif

//--- design/sar_adc_pkg.sv
// Types shared by the converter sequencer files.
// Assumes nothing of its surroundings.
package sar_adc_pkg;

    // Sequencer phases.
    typedef enum logic [1:0] {ST_IDLE, ST_POWERUP, ST_TRACK, ST_CONVERT} seq_state_e;

    // Tracking mode codes as held in the timing register.
    typedef enum logic [1:0] {TM_RESERVED, TM_POST, TM_PRE, TM_DUAL} track_mode_e;

    // Start source codes as held in the control register.
    typedef enum logic [1:0] {SRC_SOFTWARE, SRC_TIMER3, SRC_PIN, SRC_TIMER2} start_src_e;

endpackage : sar_adc_pkg

//--- design/sar_clock_divider.sv
// Conversion clock divider: one tick every divisor+1 subsystem clock ticks.
// Assumes converter_subsystem_clock_tick is a same-domain enable and run restarts the phase.
`timescale 1ns/100ps
module sar_clock_divider #(
    parameter int DIV_W = 5
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    input  wire logic             converter_subsystem_clock_tick,
    input  wire logic             run,
    input  wire logic [DIV_W-1:0] divisor,
    output logic                  sar_tick_q
);

    logic [DIV_W-1:0] cnt_q;
    wire              wrap = (cnt_q == divisor);

    // Counter restarts whenever run drops, so every phase starts aligned.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cnt_q      <= '0;
            sar_tick_q <= 1'b0;
        end else if (clk_en) begin
            if (!run) begin
                cnt_q      <= '0;
                sar_tick_q <= 1'b0;
            end else if (converter_subsystem_clock_tick) begin
                cnt_q      <= wrap ? '0 : cnt_q + 1'b1;
                sar_tick_q <= wrap;
            end else begin
                sar_tick_q <= 1'b0;
            end
        end
    end

endmodule : sar_clock_divider

//--- verification/sar_far_side.sv
// Far-side model: converter core result, timer overflows and the start pin.
// Assumes fire is a one-cycle request on clk_sys and src names the source.
`timescale 1ns/100ps
module sar_far_side (
    input  wire logic        clk_sys,
    input  wire logic        fire,
    input  wire logic [1:0]  src,
    input  wire logic [11:0] sample,
    input  wire logic        core_convert_q,
    output logic      [11:0] core_result_data,
    output logic             timer2_overflow,
    output logic             timer3_overflow,
    output logic             external_start_pin
);
    logic [2:0]  pin_q   = 3'h0;
    logic [11:0] noise_q = 12'h000;
    logic        t2_q    = 1'b0;
    logic        t3_q    = 1'b0;
    // Timer pulses last one cycle; the pin stays high long enough for a synchroniser.
    always_ff @(posedge clk_sys) begin
        t2_q    <= fire && src == 2'h3;
        t3_q    <= fire && src == 2'h1;
        pin_q   <= (fire && src == 2'h2) ? 3'h4 : pin_q - {2'b00, pin_q != 3'h0};
        noise_q <= noise_q + 12'h3a7;
    end
    // Outside a conversion the result lines move, so a stale sample cannot pass.
    assign core_result_data   = core_convert_q ? sample : noise_q;
    assign timer2_overflow    = t2_q;
    assign timer3_overflow    = t3_q;
    assign external_start_pin = pin_q != 3'h0;
endmodule : sar_far_side

//--- verification/sar_adc_sequencer_tb.sv
// Bench of the converter sequencer against an integer model of each series.
// Assumes the design files and the far-side model are compiled first.
`timescale 1ns/100ps
`include "sar_adc_defs.svh"
module sar_adc_sequencer_tb;
    logic        clk_sys = 1'b0, reset_n = 1'b0, sfr_wr_en = 1'b0, sfr_rd_en = 1'b0;
    logic        burst_osc_tick = 1'b0, window_match_event = 1'b0, fire = 1'b0;
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata_q;
    logic [1:0]  src = 2'h0;
    logic [11:0] sample = 12'h000, core_result_data;
    logic [23:0] mux_port_sel_q;
    logic        mux_temp_sel_q, mux_supply_sel_q, mux_ground_sel_q, core_power_q;
    logic        core_track_q, core_convert_q, sar_conversion_clock, conversion_done_event_q;
    logic        timer2_overflow, timer3_overflow, external_start_pin;
    logic [31:0] rng = 32'ha53b_e443;
    int          num_errors = 0, checked = 0, conv_n = 0, done_n = 0, cyc = 0, gap = 0;
    int          ticks = 0, trk = 0, last_ticks = 0, last_trk = 0, last_cyc = 0;
    logic [7:0]  reg_addr [7] = '{`ADDR_TRACK_TIMING, `ADDR_CHANNEL_SEL, `ADDR_CONFIG,
        `ADDR_RESULT_LO, `ADDR_RESULT_HI, `ADDR_CONTROL, 8'hc0};
    logic [7:0]  reg_rst [7] = '{`RST_TRACK_TIMING, 8'h1f, `RST_CONFIG, `RST_RESULT,
        `RST_RESULT, 8'h00, 8'h00};
    logic [4:0]  sel_code [6] = '{5'h00, 5'h17, 5'h18, 5'h19, 5'h1a, 5'h1f};

    sar_adc_sequencer u_dut (
        .clk_sys, .reset_n, .clk_en(1'b1), .sfr_addr, .sfr_wr_en, .sfr_rd_en, .sfr_wdata,
        .sfr_rdata_q, .burst_osc_tick, .timer2_overflow, .timer3_overflow,
        .external_start_pin, .window_match_event, .core_result_data, .mux_port_sel_q,
        .mux_temp_sel_q, .mux_supply_sel_q, .mux_ground_sel_q, .core_power_q,
        .core_track_q, .core_convert_q, .sar_conversion_clock, .conversion_done_event_q);
    sar_far_side u_far (.clk_sys, .fire, .src, .sample, .core_convert_q, .core_result_data,
        .timer2_overflow, .timer3_overflow, .external_start_pin);

    // System clock at 20 MHz.
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    // Counts conversions, done pulses and clock ticks; burst ticks run at half rate.
    always @(posedge clk_sys) begin
        cyc++;
        burst_osc_tick <= ~burst_osc_tick;
        if (conversion_done_event_q === 1'b1) done_n++;
        if (sar_conversion_clock === 1'b1) begin
            gap = cyc - last_cyc;
            last_cyc = cyc;
        end
        if (core_convert_q === 1'b1) ticks += sar_conversion_clock;
        else if (ticks != 0) begin
            conv_n++;
            last_ticks = ticks;
            ticks = 0;
        end
        if (core_track_q === 1'b1 && core_convert_q !== 1'b1) trk += sar_conversion_clock;
        else if (trk != 0) begin
            last_trk = trk;
            trk = 0;
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr_en <= 1'b1;
        @(posedge clk_sys);
        sfr_wr_en <= 1'b0;
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_rd_en <= 1'b1;
        @(posedge clk_sys);
        sfr_rd_en <= 1'b0;
        #1 chk(sfr_rdata_q, exp, what);
    endtask : rc

    // Bounded wait on the conversion or done counter; a stall counts as a mismatch.
    task automatic wait_cnt(input bit use_done, input int target);
        int n;
        n = 0;
        while ((use_done ? done_n : conv_n) < target && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
        chk(n < 3000, 1'b1, "wait");
    endtask : wait_cnt

    // One series; the model sums every sample handed to the core.
    task automatic series(input logic [1:0] rpt, input logic lj, input logic [1:0] s,
                          input logic burst);
        int q[$];
        int n, t, t0, d0, sum, w;
        logic [7:0] ctl;
        n = (rpt == 2'h0) ? 1 : 2 << rpt;
        ctl = {~burst, burst, 3'b000, lj, s};
        t0 = conv_n;
        d0 = done_n;
        wr(`ADDR_CONFIG, {5'h02, rpt, 1'b0});
        wr(`ADDR_CONTROL, ctl);
        src <= s;
        if (s != 2'h0) begin
            wr(`ADDR_CONTROL, ctl | 8'h10);
            repeat (100) @(posedge clk_sys);
            chk(conv_n, t0, "busy write");
        end
        for (int i = 0; i < (burst ? 1 : n); i++) begin
            rng = xs(rng);
            sample <= rng[11:0];
            repeat (burst ? n : 1) q.push_back(int'(rng[11:0]));
            t = conv_n + (burst ? n : 1);
            if (s == 2'h0) wr(`ADDR_CONTROL, ctl | 8'h10);
            else begin
                @(posedge clk_sys);
                fire <= 1'b1;
                @(posedge clk_sys);
                fire <= 1'b0;
            end
            w = 0;
            while (burst && core_track_q !== 1'b1 && w < 100) begin
                @(posedge clk_sys);
                #1 w++;
            end
            if (burst) chk(w >= 16 && w <= 20, 1'b1, "power-up");
            else if (i == 0) begin
                repeat (4) @(posedge clk_sys);
                rc(`ADDR_CONTROL, ctl | 8'h10, "busy");
            end
            wait_cnt(0, t);
            repeat (4) @(posedge clk_sys);
        end
        wait_cnt(1, d0 + 1);
        sum = q.sum();
        rc(`ADDR_RESULT_HI, lj ? sum[11:4] : sum[15:8], "high");
        rc(`ADDR_RESULT_LO, lj ? {sum[3:0], 4'h0} : sum[7:0], "low");
        rc(`ADDR_CONTROL, ctl | 8'h20, "done");
        chk(conv_n - t0, n, "count");
        chk(last_ticks, 13, "convert clocks");
        chk(gap, burst ? 6 : 3, "clock spacing");
        if (burst) chk({last_trk[7:0], core_power_q}, 9'h008, "track, power");
    endtask : series

    task automatic close_out();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out

    // A hang is cut off well past the expected run of a few thousand cycles.
    initial begin
        #2_000_000;
        num_errors++;
        close_out();
    end

    // Reset values, selector decode, window flag, then every series kind.
    initial begin
        logic [4:0]  c;
        logic [26:0] e;
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        #1 chk(core_power_q, 1'b0, "shutdown");
        for (int i = 0; i < 7; i++) rc(reg_addr[i], reg_rst[i], "reset");
        for (int i = 0; i < 10; i++) begin
            rng = xs(rng);
            c = (i < 6) ? sel_code[i] : rng[12:8];
            wr(`ADDR_CHANNEL_SEL, {rng[7:5], c});
            e = {(c < 5'h18) ? 24'h00_0001 << c : 24'h00_0000, c == 5'h18, c == 5'h19,
                 c > 5'h19};
            repeat (2) @(posedge clk_sys);
            #1 chk({mux_port_sel_q, mux_temp_sel_q, mux_supply_sel_q, mux_ground_sel_q},
                   e, "mux");
            rc(`ADDR_CHANNEL_SEL, {3'b000, c}, "selector");
        end
        @(posedge clk_sys);
        window_match_event <= 1'b1;
        @(posedge clk_sys);
        window_match_event <= 1'b0;
        rc(`ADDR_CONTROL, 8'h08, "window set");
        wr(`ADDR_CONTROL, 8'h00);
        rc(`ADDR_CONTROL, 8'h00, "window clear");
        series(2'h0, 1'b0, 2'h0, 1'b0);
        chk(core_power_q, 1'b1, "powered");
        // Disable in mid-track, then clear both result bytes by software writes.
        wr(`ADDR_CONTROL, 8'h90);
        repeat (10) @(posedge clk_sys);
        wr(`ADDR_CONTROL, 8'h00);
        rc(`ADDR_CONTROL, 8'h00, "abort");
        wr(`ADDR_RESULT_HI, 8'h00);
        wr(`ADDR_RESULT_LO, 8'h00);
        rc(`ADDR_RESULT_HI, 8'h00, "cleared");
        series(2'h0, 1'b1, 2'h2, 1'b0);
        series(2'h1, 1'b0, 2'h1, 1'b0);
        wr(`ADDR_TRACK_TIMING, 8'hf9);
        series(2'h2, 1'b0, 2'h3, 1'b0);
        series(2'h3, 1'b0, 2'h0, 1'b0);
        wr(`ADDR_TRACK_TIMING, 8'h15);
        series(2'h1, 1'b0, 2'h0, 1'b1);
        close_out();
    end
endmodule : sar_adc_sequencer_tb
